// file: hdl/dma_ahb_master.sv
`timescale 1ns/1ps
// Single-word or four-beat incrementing AHB master, one request at a time.
module dma_ahb_master
    import dma_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic req_in,
    input wire logic wr_in,
    input wire logic burst_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic hready_in,
    input wire logic hresp_in,
    input wire logic [31:0] hrdata_in,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic [2:0] hburst_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out,
    output logic beat_out,
    output logic wnext_out,
    output logic [31:0] rdata_out,
    output logic done_out,
    output logic err_out
);
    logic [2:0] addr_left;
    logic [2:0] data_left;
    logic data_phase;
    logic busy;

    // ------------------------------------------------------------------
    // Address phase
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            haddr_out <= 32'h0;
            htrans_out <= HTRANS_IDLE;
            hburst_out <= HBURST_SINGLE;
            hwrite_out <= 1'b0;
            hsize_out <= HSIZE_WORD;
            addr_left <= 3'h0;
            busy <= 1'b0;
        end else if (!busy && req_in) begin
            haddr_out <= addr_in;
            htrans_out <= HTRANS_NONSEQ;
            hburst_out <= burst_in ? HBURST_INCR4 : HBURST_SINGLE;
            hwrite_out <= wr_in;
            addr_left <= burst_in ? 3'(BURST_BEATS - 1) : 3'h0;
            busy <= 1'b1;
        end else if (hready_in && htrans_out != HTRANS_IDLE) begin
            if (addr_left != 3'h0) begin
                haddr_out <= haddr_out + 32'h4;
                htrans_out <= HTRANS_SEQ;
                addr_left <= addr_left - 3'h1;
            end else begin
                htrans_out <= HTRANS_IDLE;
            end
        end else if (done_out) begin
            busy <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Data phase
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            data_phase <= 1'b0;
            data_left <= 3'h0;
            beat_out <= 1'b0;
            done_out <= 1'b0;
            err_out <= 1'b0;
            rdata_out <= 32'h0;
            hwdata_out <= 32'h0;
        end else begin
            beat_out <= 1'b0;
            done_out <= 1'b0;
            err_out <= 1'b0;
            if (!busy && req_in) begin
                data_left <= burst_in ? 3'(BURST_BEATS - 1) : 3'h0;
            end
            if (hready_in && htrans_out != HTRANS_IDLE) begin
                data_phase <= 1'b1;
                hwdata_out <= wdata_in;
            end else if (hready_in && data_phase) begin
                data_phase <= 1'b0;
            end
            if (hready_in && data_phase) begin
                beat_out <= 1'b1;
                rdata_out <= hrdata_in;
                err_out <= hresp_in;
                if (data_left == 3'h0) begin
                    done_out <= 1'b1;
                end else begin
                    data_left <= data_left - 3'h1;
                end
            end
        end
    end

    // Write data for the next address phase must be ready beside it.
    assign wnext_out = hready_in && htrans_out != HTRANS_IDLE;
endmodule : dma_ahb_master

// file: hdl/dma_linked_list_engine.sv
`timescale 1ns/1ps
module dma_linked_list_engine
    import dma_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [11:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic [2:0] hburst_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out,
    input wire logic hready_in,
    input wire logic hresp_in,
    input wire logic [31:0] hrdata_in,
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_valid_in,
    input wire logic rx_last_in,
    output logic rx_ready_out,
    output logic [1:0] first_serial_ctrl_channel_field,
    output logic [1:0] second_serial_ctrl_channel_field,
    output logic [1:0] third_serial_ctrl_channel_field,
    output logic tx_busy_out,
    output logic rx_busy_out
);
    typedef enum logic [7:0] {
        S_IDLE = 8'h01, S_DESC = 8'h02, S_TXRD = 8'h04, S_TXOUT = 8'h08,
        S_RXIN = 8'h10, S_RXWR = 8'h20, S_WBACK = 8'h40, S_ERR = 8'h80
    } state_t;

    state_t state;
    logic [5:0] chan_sel;
    logic [19:0] tx_head;
    logic [19:0] rx_head;
    logic tx_go;
    logic rx_go;
    logic tx_pend;
    logic rx_pend;
    logic dir_rx;
    logic [31:0] desc_addr;
    logic [31:0] descriptor_word_zero;
    logic [31:0] descriptor_buffer_pointer_word;
    logic [31:0] descriptor_next_pointer_word;
    logic [1:0] word_idx;
    logic [11:0] byte_cnt;
    logic [31:0] data_word;
    logic [1:0] lane;
    logic [31:0] buf_ptr;
    logic [31:0] tx_next_desc;
    logic [31:0] rx_next_desc;
    logic rx_end;
    logic m_req, m_wr, m_burst, m_beat, m_done, m_err;
    logic [31:0] m_addr, m_wdata, m_rdata;
    logic [11:0] desc_len;
    logic in_space;

    assign desc_len = descriptor_word_zero[LEN_HI:LEN_LO];
    assign in_space = (desc_addr - DMA_SPACE_BASE) < DMA_SPACE_BYTES;

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            chan_sel <= CHAN_SEL_RESET[5:0];
            tx_head <= 20'h0;
            rx_head <= 20'h0;
            tx_go <= 1'b0;
            rx_go <= 1'b0;
        end else begin
            tx_go <= 1'b0;
            rx_go <= 1'b0;
            if (reg_wr_in) begin
                case (reg_addr_in)
                    CHAN_SEL_OFS: begin
                        for (int i = 0; i < 3; i++) begin
                            // Reserved code is refused; field keeps value.
                            if (reg_wdata_in[2*i +: 2] != CHAN_RSVD) begin
                                chan_sel[2*i +: 2] <= reg_wdata_in[2*i +: 2];
                            end
                        end
                    end
                    TX_LIST_OFS: begin
                        tx_head <= reg_wdata_in[LIST_ADDR_BITS-1:0];
                        tx_go <= reg_wdata_in[LIST_GO_POS];
                    end
                    RX_LIST_OFS: begin
                        rx_head <= reg_wdata_in[LIST_ADDR_BITS-1:0];
                        rx_go <= reg_wdata_in[LIST_GO_POS];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 32'h0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                CHAN_SEL_OFS: reg_rdata_out <= {26'h0, chan_sel};
                TX_LIST_OFS: reg_rdata_out <= {12'h0, tx_head};
                RX_LIST_OFS: reg_rdata_out <= {12'h0, rx_head};
                STATUS_OFS: reg_rdata_out <= {29'h0, state == S_ERR,
                                              rx_busy_out, tx_busy_out};
                default: reg_rdata_out <= 32'h0;
            endcase
        end else begin
            reg_rdata_out <= 32'h0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            first_serial_ctrl_channel_field <= CHAN_NONE;
            second_serial_ctrl_channel_field <= CHAN_NONE;
            third_serial_ctrl_channel_field <= CHAN_NONE;
        end else begin
            first_serial_ctrl_channel_field <= chan_sel[FIRST_FIELD_POS +: 2];
            second_serial_ctrl_channel_field <=
                chan_sel[SECOND_FIELD_POS +: 2];
            third_serial_ctrl_channel_field <= chan_sel[THIRD_FIELD_POS +: 2];
        end
    end

    // ------------------------------------------------------------------
    // List walker: one AHB master shared, lists interleave per element.
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            state <= S_IDLE;
            tx_pend <= 1'b0;
            rx_pend <= 1'b0;
            dir_rx <= 1'b0;
            desc_addr <= 32'h0;
            descriptor_word_zero <= 32'h0;
            descriptor_buffer_pointer_word <= 32'h0;
            descriptor_next_pointer_word <= 32'h0;
            word_idx <= 2'h0;
            byte_cnt <= 12'h0;
            data_word <= 32'h0;
            lane <= 2'h0;
            buf_ptr <= 32'h0;
            tx_next_desc <= 32'h0;
            rx_next_desc <= 32'h0;
            rx_end <= 1'b0;
            m_req <= 1'b0;
            tx_data_out <= 8'h0;
            tx_valid_out <= 1'b0;
            rx_ready_out <= 1'b0;
            tx_busy_out <= 1'b0;
            rx_busy_out <= 1'b0;
        end else begin
            m_req <= 1'b0;
            tx_busy_out <= tx_pend || tx_go;
            rx_busy_out <= rx_pend || rx_go;
            case (state)
                S_IDLE: begin
                    // Alternate directions so neither list starves.
                    if (rx_pend && (!tx_pend || !dir_rx)) begin
                        dir_rx <= 1'b1;
                        desc_addr <= rx_next_desc;
                        state <= S_DESC;
                        m_req <= 1'b1;
                        word_idx <= 2'h0;
                    end else if (tx_pend) begin
                        dir_rx <= 1'b0;
                        desc_addr <= tx_next_desc;
                        state <= S_DESC;
                        m_req <= 1'b1;
                        word_idx <= 2'h0;
                    end
                end
                S_DESC: begin
                    if (m_beat) begin
                        case (word_idx)
                            2'h0: descriptor_word_zero <= m_rdata;
                            2'h1: descriptor_buffer_pointer_word <= m_rdata;
                            default: descriptor_next_pointer_word <= m_rdata;
                        endcase
                        word_idx <= word_idx + 2'h1;
                    end
                    if (m_done && word_idx < 2'(DESC_WORDS - 1)) begin
                        m_req <= 1'b1;
                    end else if (m_done || m_err) begin
                        byte_cnt <= 12'h0;
                        lane <= 2'h0;
                        rx_end <= 1'b0;
                        buf_ptr <= descriptor_buffer_pointer_word;
                        if (m_err || !in_space) begin
                            state <= S_ERR;
                        end else if (!descriptor_word_zero[OWNER_POS]) begin
                            state <= S_ERR;
                        end else if (dir_rx) begin
                            state <= S_RXIN;
                        end else if (desc_len == 12'h0) begin
                            state <= S_WBACK;
                            m_req <= 1'b1;
                        end else begin
                            state <= S_TXRD;
                            m_req <= 1'b1;
                        end
                    end
                end
                S_TXRD: begin
                    if (m_beat) begin
                        data_word <= m_rdata;
                        state <= S_TXOUT;
                        lane <= 2'h0;
                    end
                end
                S_TXOUT: begin
                    if (!tx_valid_out || tx_ready_in) begin
                        if (tx_valid_out) begin
                            byte_cnt <= byte_cnt + 12'h1;
                        end
                        if (tx_valid_out && byte_cnt + 12'h1 == desc_len) begin
                            tx_valid_out <= 1'b0;
                            state <= S_WBACK;
                            m_req <= 1'b1;
                        end else if (tx_valid_out && lane == 2'h0) begin
                            tx_valid_out <= 1'b0;
                            buf_ptr <= buf_ptr + 32'h4;
                            state <= S_TXRD;
                            m_req <= 1'b1;
                        end else begin
                            tx_data_out <= data_word[8*lane +: 8];
                            tx_valid_out <= 1'b1;
                            lane <= lane + 2'h1;
                        end
                    end
                end
                S_RXIN: begin
                    rx_ready_out <= 1'b1;
                    if (rx_valid_in && rx_ready_out) begin
                        data_word[8*lane +: 8] <= rx_data_in;
                        lane <= lane + 2'h1;
                        byte_cnt <= byte_cnt + 12'h1;
                        rx_end <= rx_last_in;
                        if (lane == 2'h3 || rx_last_in || byte_cnt + 12'h1
                            == descriptor_word_zero[SIZE_HI:SIZE_LO]) begin
                            rx_ready_out <= 1'b0;
                            state <= S_RXWR;
                            m_req <= 1'b1;
                        end
                    end
                end
                S_RXWR: begin
                    // Each word holding received bytes is written whole; words past the last stay put.
                    if (m_done) begin
                        buf_ptr <= buf_ptr + 32'h4;
                        lane <= 2'h0;
                        if (rx_end || byte_cnt ==
                            descriptor_word_zero[SIZE_HI:SIZE_LO]) begin
                            descriptor_word_zero[LEN_HI:LEN_LO] <= byte_cnt;
                            descriptor_word_zero[EOF_POS] <= rx_end;
                            state <= S_WBACK;
                            m_req <= 1'b1;
                        end else begin
                            state <= S_RXIN;
                        end
                    end
                end
                S_WBACK: begin
                    if (m_done) begin
                        state <= S_IDLE;
                        if (descriptor_word_zero[EOF_POS]
                            || descriptor_next_pointer_word == 32'h0) begin
                            if (dir_rx) rx_pend <= 1'b0;
                            else tx_pend <= 1'b0;
                            descriptor_next_pointer_word <= 32'h0;
                        end else if (dir_rx) begin
                            rx_next_desc <= descriptor_next_pointer_word;
                        end else begin
                            tx_next_desc <= descriptor_next_pointer_word;
                        end
                    end
                end
                S_ERR: begin
                    if (dir_rx) rx_pend <= 1'b0;
                    else tx_pend <= 1'b0;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
            // A start in the cycle that ends a list must beat the clear.
            if (tx_go) begin
                tx_pend <= 1'b1;
                tx_next_desc <= {DMA_SPACE_BASE[31:20], tx_head};
            end
            if (rx_go) begin
                rx_pend <= 1'b1;
                rx_next_desc <= {DMA_SPACE_BASE[31:20], rx_head};
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus request formation
    // ------------------------------------------------------------------
    always_comb begin
        m_wr = state == S_RXWR || state == S_WBACK;
        m_burst = 1'b0;
        m_addr = buf_ptr;
        m_wdata = data_word;
        if (state == S_DESC) begin
            m_addr = desc_addr + {28'h0, word_idx, 2'h0};
        end else if (state == S_WBACK) begin
            m_addr = desc_addr;
            m_wdata = {1'b0, descriptor_word_zero[30:0]};
        end
    end

    dma_ahb_master dma_ahb_master_inst (
        .clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
        .req_in(m_req), .wr_in(m_wr), .burst_in(m_burst),
        .addr_in(m_addr), .wdata_in(m_wdata),
        .hready_in(hready_in), .hresp_in(hresp_in), .hrdata_in(hrdata_in),
        .haddr_out(haddr_out), .htrans_out(htrans_out),
        .hburst_out(hburst_out), .hwrite_out(hwrite_out),
        .hsize_out(hsize_out), .hwdata_out(hwdata_out),
        .beat_out(m_beat), .wnext_out(), .rdata_out(m_rdata),
        .done_out(m_done), .err_out(m_err)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_go_clears: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        tx_go |=> !tx_go) else $error("start bit not cleared");
    a_no_rsvd_sel: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in) first_serial_ctrl_channel_field != CHAN_RSVD)
        else $error("reserved channel code");
    a_owner_back: assert property (@(posedge clk_sys_in)
        disable iff (!nrst_in) state == S_WBACK |-> !m_wdata[OWNER_POS])
        else $error("owner not returned");
    a_rx_tail: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        state == S_RXIN |-> byte_cnt <= descriptor_word_zero[SIZE_HI:SIZE_LO])
        else $error("receive overran buffer");
    a_tx_len: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        state == S_TXOUT |-> byte_cnt <= desc_len)
        else $error("transmit overran length");
    a_rx_ready: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        rx_ready_out |-> state == S_RXIN)
        else $error("receive ready outside receive");
    a_ahb_word: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        htrans_out != HTRANS_IDLE |-> haddr_out[1:0] == 2'h0)
        else $error("unaligned bus address");
    a_stop_end: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        state == S_WBACK && m_done && descriptor_word_zero[EOF_POS] && !dir_rx
        && !tx_go |=> !tx_pend) else $error("fetch after end");
endmodule : dma_linked_list_engine

// file: hdl/dma_pkg.sv
package dma_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] CHAN_SEL_OFS = 12'h5a8;
    localparam logic [11:0] TX_LIST_OFS = 12'h5b0;
    localparam logic [11:0] RX_LIST_OFS = 12'h5b4;
    localparam logic [11:0] STATUS_OFS = 12'h5b8;
    localparam logic [31:0] CHAN_SEL_RESET = 32'h0000_0000;
    localparam int FIRST_FIELD_POS = 0;
    localparam int SECOND_FIELD_POS = 2;
    localparam int THIRD_FIELD_POS = 4;
    localparam int LIST_ADDR_BITS = 20;
    localparam int LIST_GO_POS = 29;
    localparam logic [1:0] CHAN_NONE = 2'h0;
    localparam logic [1:0] CHAN_ONE = 2'h1;
    localparam logic [1:0] CHAN_TWO = 2'h2;
    localparam logic [1:0] CHAN_RSVD = 2'h3;

    // ------------------------------------------------------------------
    // Descriptor layout
    // ------------------------------------------------------------------
    localparam int DESC_WORDS = 3;
    localparam int OWNER_POS = 31;
    localparam int EOF_POS = 30;
    localparam int LEN_HI = 23;
    localparam int LEN_LO = 12;
    localparam int SIZE_HI = 11;
    localparam int SIZE_LO = 0;
    localparam int BURST_BEATS = 4;
    // 328 KB reachable window.
    localparam logic [31:0] DMA_SPACE_BYTES = 32'd328 * 32'd1024;
    localparam logic [31:0] DMA_SPACE_BASE = 32'h3ffa_e000;

    // AHB encodings.
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HBURST_SINGLE = 3'h0;
    localparam logic [2:0] HBURST_INCR4 = 3'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : dma_pkg

// file: tb/ahb_sram_model.sv
`timescale 1ns/1ps
module ahb_sram_model (
    input wire logic clk_sys_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic stall_in,
    output logic hready_out,
    output logic [31:0] hrdata_out
);
    logic [31:0] mem [0:255];
    logic [7:0] ap_idx = 8'h0;
    logic ap_on = 1'b0;
    logic ap_wr = 1'b0;
    logic flip = 1'b0;
    // Outside a read data phase the bus shows a moving pattern, so the
    // engine cannot profit from stale data.
    assign hready_out = !stall_in;
    assign hrdata_out = (ap_on && !ap_wr && !stall_in) ? mem[ap_idx] :
        {16{flip, !flip}};
    always @(posedge clk_sys_in) begin
        flip <= !flip;
        if (hready_out) begin
            if (ap_on && ap_wr)
                mem[ap_idx] <= hwdata_in;
            ap_on <= htrans_in[1];
            ap_wr <= hwrite_in;
            ap_idx <= haddr_in[9:2];
        end
    end
endmodule : ahb_sram_model

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dma_pkg::*;
    logic clk_sys_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0, hresp_in = 1'b0, stall = 1'b0;
    logic tx_ready_in = 1'b0, rx_valid_in = 1'b0, rx_last_in = 1'b0;
    logic [11:0] reg_addr_in = 12'h0;
    logic [31:0] reg_wdata_in = 32'h0, v;
    logic [7:0] rx_data_in = 8'h0, tx_data_out;
    logic [31:0] reg_rdata_out, haddr_out, hwdata_out, hrdata_in;
    logic [1:0] htrans_out, first_serial_ctrl_channel_field;
    logic [1:0] second_serial_ctrl_channel_field;
    logic [1:0] third_serial_ctrl_channel_field;
    logic [2:0] hburst_out, hsize_out;
    logic hwrite_out, hready_in, tx_valid_out, rx_ready_out;
    logic tx_busy_out, rx_busy_out;
    logic [39:0] got;
    int n_fail = 0, n_checks = 0, k, n;
    dma_linked_list_engine dma_linked_list_engine_inst (.*);
    ahb_sram_model ahb_sram_model_inst (.clk_sys_in(clk_sys_in),
        .haddr_in(haddr_out), .htrans_in(htrans_out),
        .hwrite_in(hwrite_out), .hwdata_in(hwdata_out), .stall_in(stall),
        .hready_out(hready_in), .hrdata_out(hrdata_in));
    initial forever #50 clk_sys_in = !clk_sys_in;
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [39:0] exp);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 check(reg_rdata_out, exp);
    endtask : rd
    task automatic idle_wait();
        for (k = 0; k < 3000 && (tx_busy_out || rx_busy_out); k++)
            @(posedge clk_sys_in);
        if (k == 3000) n_fail++;
    endtask : idle_wait
    task automatic t_regs();
        rd(CHAN_SEL_OFS, CHAN_SEL_RESET);
        wr(CHAN_SEL_OFS, 32'h0000_0021);
        rd(CHAN_SEL_OFS, 32'h0000_0021);
        wr(CHAN_SEL_OFS, 32'h0000_0023);
        rd(CHAN_SEL_OFS, 32'h0000_0021);
        check({third_serial_ctrl_channel_field, second_serial_ctrl_channel_field,
            first_serial_ctrl_channel_field}, 40'h21);
        rd(12'h7fc, 32'h0);
    endtask : t_regs
    task automatic t_tx();
        ahb_sram_model_inst.mem[0] = 32'hc000_5008;
        ahb_sram_model_inst.mem[1] = 32'h3ffa_e040;
        ahb_sram_model_inst.mem[2] = 32'h0;
        ahb_sram_model_inst.mem[16] = 32'h4433_2211;
        ahb_sram_model_inst.mem[17] = 32'h0000_0055;
        stall <= 1'b1;
        wr(TX_LIST_OFS, 32'h200a_e000);
        rd(STATUS_OFS, 32'h1);
        repeat (3) @(posedge clk_sys_in);
        stall <= 1'b0;
        tx_ready_in <= 1'b1;
        n = 0;
        for (k = 0; k < 3000 && n < 5; k++) begin
            @(posedge clk_sys_in);
            if (tx_valid_out === 1'b1) begin
                got[n*8+:8] = tx_data_out;
                n++;
            end
        end
        check(got, 40'h55_4433_2211);
        idle_wait();
        check(ahb_sram_model_inst.mem[0], 32'h4000_5008);
        repeat (20) @(posedge clk_sys_in) check(htrans_out, HTRANS_IDLE);
    endtask : t_tx
    task automatic t_rx();
        ahb_sram_model_inst.mem[4] = 32'h8000_0008;
        ahb_sram_model_inst.mem[5] = 32'h3ffa_e080;
        ahb_sram_model_inst.mem[6] = 32'h0;
        ahb_sram_model_inst.mem[33] = 32'hffff_ffff;
        wr(RX_LIST_OFS, 32'h200a_e010);
        for (n = 0; n < 3; n++) begin
            rx_data_in <= 8'ha1 + 8'(n * 17);
            rx_last_in <= (n == 2);
            rx_valid_in <= 1'b1;
            k = 0;
            do @(posedge clk_sys_in); while (rx_ready_out !== 1'b1 && ++k < 500);
        end
        rx_valid_in <= 1'b0;
        idle_wait();
        check(ahb_sram_model_inst.mem[4], 32'h4000_3008);
        check(ahb_sram_model_inst.mem[32][23:0], 24'hc3_b2a1);
        check(ahb_sram_model_inst.mem[33], 32'hffff_ffff);
    endtask : t_rx
    task automatic t_own();
        ahb_sram_model_inst.mem[8] = 32'h4000_1008;
        ahb_sram_model_inst.mem[9] = 32'h3ffa_e0c0;
        ahb_sram_model_inst.mem[10] = 32'h0;
        wr(TX_LIST_OFS, 32'h200a_e020);
        n = 0;
        for (k = 0; k < 100; k++) begin
            @(posedge clk_sys_in);
            if (tx_valid_out !== 1'b0) n++;
        end
        check(n, 0);
        check(tx_busy_out, 1'b0);
        check(ahb_sram_model_inst.mem[8], 32'h4000_1008);
    endtask : t_own
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test
    initial begin
        #2000000;
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        t_regs();
        t_tx();
        t_rx();
        t_own();
        finish_test();
    end
endmodule : tb_top
